// *** logic/mic_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz master clock
// Notes:   Definitions only
//
// Functional notes
// RULE1 - Reduced power slows pipeline clock to quarter
// RULE2 - Reduced power: system and tertiary clocks quarter
// RULE3 - Clock switch completes within 1-16 cycles
// RULE4 - Normal: pipeline ratio from pins, system equals master
// RULE5 - Cold reset clears reduced power bit
// RULE6 - FP width bit selects 64-bit registers
// RULE7 - Write rate field selects pattern, resets single
// RULE8 - Byte order bit resets to big-endian
// RULE9 - Swap bit reverses user mode byte order
// RULE10 - Trace bit forces miss on flow change
// RULE11 - Boot bit picks exception vector base
// RULE12 - Kernel wide bit uses extended refill vector
// RULE13 - Supervisor wide bit: wide opcodes, extended vector
// RULE14 - User wide bit: wide opcodes, else compatible
// RULE15 - Global enable clear blocks maskable interrupts
// RULE16 - Nonmaskable from pin or external write
// RULE17 - Nonmaskable never masked, goes reset vector
// RULE18 - External pins set cause bits, maskable
// RULE19 - External write enables set external bits
// RULE20 - Software pending bits change only by software
// RULE21 - Count equals compare sets timer bit
// RULE22 - Take interrupt: pending, masked, enabled, idle
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// ==========================================================
// Register numbers
`define MIC_IDX_COUNT     5'h09
`define MIC_IDX_COMPARE   5'h0b
`define MIC_IDX_STATUS    5'h0c
`define MIC_IDX_CAUSE     5'h0d
`define MIC_IDX_CONFIG    5'h10

// ==========================================================
// Status fields
`define MIC_ST_IE         0
`define MIC_ST_EXL        1
`define MIC_ST_ERL        2
`define MIC_ST_KSU_LO     3
`define MIC_ST_UX         5
`define MIC_ST_SX         6
`define MIC_ST_KX         7
`define MIC_ST_IM_LO      8
`define MIC_ST_BEV        22
`define MIC_ST_ITS        24
`define MIC_ST_RE         25
`define MIC_ST_FR         26
`define MIC_ST_RP         27
`define MIC_ST_WMASK      32'h0f40_ffff
`define MIC_ST_RESET      32'h0040_0004
`define MIC_KSU_USER      2'h2
`define MIC_KSU_SUPER     2'h1

// ==========================================================
// Cause and configuration fields
`define MIC_CA_IP_LO      8
`define MIC_CF_EP_LO      24
`define MIC_CF_BE         15
`define MIC_EP_RESET      4'h0
`define MIC_BE_RESET      1'b1

// ==========================================================
// External write data cycle
`define MIC_XW_NMI_EN     22
`define MIC_XW_NMI_VAL    6
`define MIC_XW_IRQ_EN_LO  16
`define MIC_XW_IRQ_VAL_LO 0

// ==========================================================
// Vectors and timing
`define MIC_VEC_BOOT      32'hbfc0_0000
`define MIC_VEC_NORMAL    32'h8000_0000
`define MIC_VEC_RESET     32'hbfc0_0000
`define MIC_SWITCH_MAX    16
`define MIC_SLOW_DIV      4

`endif

// *** logic/mic_pkg.sv ***
// Purpose: Types shared by the mode and interrupt control block
// Assumes: Constants come from mic_defs.svh
// Notes:   Types only
`default_nettype none
package mic_pkg;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        wr;
      logic [4:0]  addr;
      logic [31:0] data;
   } mic_cp0_req_t;

   typedef struct packed {
      logic        sys_en;
      logic        tert_en;
      logic [3:0]  pipe_half_mult;
      logic        pipe_quarter;
      logic        reduced;
   } mic_clk_t;

   // ==========================================================
   // Clock generator state
   typedef enum logic [2:0] {
      MIC_CG_NORMAL  = 3'b001,
      MIC_CG_SWITCH  = 3'b010,
      MIC_CG_REDUCED = 3'b100
   } mic_cg_state_t;

   typedef struct packed {
      mic_cg_state_t st;
      logic [1:0]    div;
      logic [4:0]    wait_cnt;
      logic [1:0]    rs1;
      logic [1:0]    rs2;
      logic [1:0]    rs3;
      logic [1:0]    ratio;
   } mic_cg_st_t;

   // ==========================================================
   // Interrupt source state
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] lvl;
      logic [4:0] xw_ip;
      logic       xw_nmi;
      logic       nmi_pulse;
   } mic_src_st_t;

   // ==========================================================
   // Top state
   typedef struct packed {
      logic [31:0] status;
      logic [3:0]  ep;
      logic        be;
      logic [1:0]  sw_ip;
      logic        timer_ip;
      logic [31:0] count;
      logic [31:0] compare;
      logic        irq_take;
      logic        nmi_take;
      logic [31:0] vector;
      logic [31:0] rd_data;
   } mic_top_st_t;

endpackage
`default_nettype wire

// *** logic/mic_clkgen.sv ***
// Purpose: Clock enable generation for normal and reduced power
// Assumes: Ratio pins asynchronous, master clock is clk_in
// Notes:   Enables stand in for divided clocks
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.svh"
module mic_clkgen (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             ce_in,
   input  wire logic             rp_req_in,
   input  wire logic [1:0]       ratio_pins_in,
   output mic_pkg::mic_clk_t     clk_out
);
   mic_pkg::mic_cg_st_t s_r;
   mic_pkg::mic_cg_st_t s_nxt;
   logic                slow;

   // ==========================================================
   // Helpers
   function automatic logic [3:0] half_mult(input logic [1:0] sel);
      unique case (sel)
         2'h0:    half_mult = 4'h6;
         2'h1:    half_mult = 4'h4;
         2'h2:    half_mult = 4'h3;
         default: half_mult = 4'h2;
      endcase
   endfunction

   assign slow = (s_r.st == mic_pkg::MIC_CG_REDUCED);

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt     = s_r;
      s_nxt.rs1 = ratio_pins_in;
      s_nxt.rs2 = s_r.rs1;
      s_nxt.rs3 = s_r.rs2;
      if (s_r.rs2 == s_r.rs3) begin
         s_nxt.ratio = s_r.rs3;
      end
      s_nxt.div = s_r.div + 2'h1;
      unique case (s_r.st)
         mic_pkg::MIC_CG_NORMAL: begin
            if (rp_req_in) begin
               s_nxt.st       = mic_pkg::MIC_CG_SWITCH;
               s_nxt.wait_cnt = 5'h0;
            end
         end
         mic_pkg::MIC_CG_SWITCH: begin
            // Switch on a divider boundary so no short enable slips out
            s_nxt.wait_cnt = s_r.wait_cnt + 5'h1;
            if (s_r.div == 2'h3) begin
               s_nxt.st = rp_req_in ? mic_pkg::MIC_CG_REDUCED : mic_pkg::MIC_CG_NORMAL; // RULE3
            end
         end
         mic_pkg::MIC_CG_REDUCED: begin
            if (!rp_req_in) begin
               s_nxt.st       = mic_pkg::MIC_CG_SWITCH;
               s_nxt.wait_cnt = 5'h0;
            end
         end
         default: s_nxt.st = mic_pkg::MIC_CG_NORMAL;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_r <= '{st: mic_pkg::MIC_CG_NORMAL, div: 2'h0, wait_cnt: 5'h0, rs1: 2'h0, rs2: 2'h0,
                  rs3: 2'h0, ratio: 2'h0}; // RULE5
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      clk_out.reduced        = slow;
      clk_out.sys_en         = ce_in && (!slow || s_r.div == 2'h3); // RULE2 RULE4
      clk_out.tert_en        = ce_in && (!slow || s_r.div == 2'h3); // RULE2
      clk_out.pipe_half_mult = half_mult(s_r.ratio); // RULE4
      clk_out.pipe_quarter   = slow; // RULE1
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_switch_bound: assert property (s_r.st == mic_pkg::MIC_CG_SWITCH |-> s_r.wait_cnt < 5'(`MIC_SWITCH_MAX)) // RULE3
      else $error("clock switch took too long");
   chk_slow_gap: assert property (slow && clk_out.sys_en ##1 slow |-> !clk_out.sys_en [*3]) // RULE2
      else $error("reduced system enable too frequent");
   cov_enter_slow: cover property (!slow ##1 slow);
endmodule
`default_nettype wire

// *** logic/mic_irq_src.sv ***
// Purpose: Synchronise interrupt pins and apply external writes
// Assumes: Pins active low and asynchronous
// Notes:   Pin change counts once second and third stages agree
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.svh"
module mic_irq_src (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ce_in,
   input  wire logic        nmi_n_in,
   input  wire logic [4:0]  ext_irq_n_in,
   input  wire logic        ext_wr_in,
   input  wire logic [31:0] ext_data_in,
   output logic      [4:0]  ext_ip_out,
   output logic             nmi_pulse_out
);
   mic_pkg::mic_src_st_t s_r;
   mic_pkg::mic_src_st_t s_nxt;
   logic [4:0]           en;
   logic [4:0]           val;

   assign en  = ext_data_in[`MIC_XW_IRQ_EN_LO +: 5];
   assign val = ext_data_in[`MIC_XW_IRQ_VAL_LO +: 5];

   always_comb begin
      s_nxt           = s_r;
      s_nxt.s1        = ~{nmi_n_in, ext_irq_n_in};
      s_nxt.s2        = s_r.s1;
      s_nxt.s3        = s_r.s2;
      for (int i = 0; i < 6; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.lvl[i] = s_r.s3[i];
         end
      end
      s_nxt.nmi_pulse = 1'b0;
      if (ext_wr_in) begin
         s_nxt.xw_ip = (s_r.xw_ip & ~en) | (val & en); // RULE19
         if (ext_data_in[`MIC_XW_NMI_EN]) begin
            s_nxt.xw_nmi = ext_data_in[`MIC_XW_NMI_VAL];
         end
      end
      // Edge of either source raises one pulse, never gated here
      s_nxt.nmi_pulse = (s_nxt.lvl[5] && !s_r.lvl[5]) || (s_nxt.xw_nmi && !s_r.xw_nmi); // RULE16
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_r <= '0;
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   assign ext_ip_out    = s_r.lvl[4:0] | s_r.xw_ip; // RULE18
   assign nmi_pulse_out = s_r.nmi_pulse;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_xw_nmi: assert property (ce_in && ext_wr_in && ext_data_in[`MIC_XW_NMI_EN] && ext_data_in[`MIC_XW_NMI_VAL]
                                && !s_r.xw_nmi |=> nmi_pulse_out) // RULE16
      else $error("external write nonmaskable lost");
   chk_xw_irq: assert property (ce_in && ext_wr_in && en[0] && val[0] |=> ext_ip_out[0]) // RULE19
      else $error("external write interrupt not set");
   cov_pin_nmi: cover property (nmi_pulse_out && s_r.lvl[5]);
endmodule
`default_nettype wire

// *** logic/mic_top.sv ***
// Purpose: Processor mode decode and interrupt gathering
// Assumes: Coprocessor moves arrive on cp0_req_in, one per cycle
// Notes:   Read data appears the cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.svh"
module mic_top #(
   parameter int COUNT_W = 32
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  ce_in,
   input  wire mic_pkg::mic_cp0_req_t cp0_req_in,
   output logic [31:0]                cp0_rd_data_out,
   input  wire logic                  nmi_n_in,
   input  wire logic [4:0]            ext_irq_n_in,
   input  wire logic                  ext_wr_in,
   input  wire logic [31:0]           ext_data_in,
   input  wire logic [1:0]            clock_ratio_select_in,
   input  wire logic                  flow_change_in,
   input  wire logic                  tlb_miss_in,
   output mic_pkg::mic_clk_t          clk_out,
   output logic                       fp_wide_regs_out,
   output logic [3:0]                 write_rate_out,
   output logic                       big_endian_out,
   output logic                       user_swap_active_out,
   output logic                       force_icache_miss_out,
   output logic                       xtlb_refill_out,
   output logic                       wide_ops_ok_out,
   output logic                       compat_user_xlate_out,
   output logic [31:0]                exc_base_out,
   output logic                       irq_take_out,
   output logic                       nmi_take_out,
   output logic [31:0]                take_vector_out
);
   if (COUNT_W != 32) begin : g_bad_width
      $error("mic_top: COUNT_W must be 32");
   end

   mic_pkg::mic_top_st_t s_r;
   mic_pkg::mic_top_st_t s_nxt;
   logic [4:0]           ext_ip;
   logic                 nmi_pulse;
   logic [7:0]           ip;
   logic [7:0]           im;
   logic [1:0]           ksu;
   logic                 busy;
   logic                 user_mode;
   logic                 super_mode;

   // ==========================================================
   // Helpers
   function automatic logic wr_hit(input mic_pkg::mic_cp0_req_t r, input logic [4:0] idx);
      wr_hit = r.wr && (r.addr == idx);
   endfunction

   // ==========================================================
   // Sub blocks
   mic_clkgen u_clkgen (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .ce_in         (ce_in),
      .rp_req_in     (s_r.status[`MIC_ST_RP]),
      .ratio_pins_in (clock_ratio_select_in),
      .clk_out       (clk_out)
   );

   mic_irq_src u_src (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .ce_in         (ce_in),
      .nmi_n_in      (nmi_n_in),
      .ext_irq_n_in  (ext_irq_n_in),
      .ext_wr_in     (ext_wr_in),
      .ext_data_in   (ext_data_in),
      .ext_ip_out    (ext_ip),
      .nmi_pulse_out (nmi_pulse)
   );

   // ==========================================================
   // Decode
   assign ksu        = s_r.status[`MIC_ST_KSU_LO +: 2];
   assign busy       = s_r.status[`MIC_ST_EXL] || s_r.status[`MIC_ST_ERL];
   assign user_mode  = (ksu == `MIC_KSU_USER) && !busy;
   assign super_mode = (ksu == `MIC_KSU_SUPER) && !busy;
   assign im         = s_r.status[`MIC_ST_IM_LO +: 8];
   assign ip         = {s_r.timer_ip, ext_ip, s_r.sw_ip}; // RULE18 RULE21 RULE20

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt          = s_r;
      s_nxt.count    = s_r.count + 32'h1;
      s_nxt.irq_take = 1'b0;
      s_nxt.nmi_take = 1'b0;
      if (wr_hit(cp0_req_in, `MIC_IDX_STATUS)) begin
         s_nxt.status = cp0_req_in.data & `MIC_ST_WMASK; // RULE1 RULE6 RULE9 RULE10 RULE11
      end
      if (wr_hit(cp0_req_in, `MIC_IDX_CONFIG)) begin
         s_nxt.ep = cp0_req_in.data[`MIC_CF_EP_LO +: 4]; // RULE7
         s_nxt.be = cp0_req_in.data[`MIC_CF_BE]; // RULE8
      end
      if (wr_hit(cp0_req_in, `MIC_IDX_CAUSE)) begin
         s_nxt.sw_ip = cp0_req_in.data[`MIC_CA_IP_LO +: 2]; // RULE20
      end
      if (wr_hit(cp0_req_in, `MIC_IDX_COUNT)) begin
         s_nxt.count = cp0_req_in.data;
      end
      if (wr_hit(cp0_req_in, `MIC_IDX_COMPARE)) begin
         s_nxt.compare  = cp0_req_in.data;
         s_nxt.timer_ip = 1'b0;
      end
      // Match comes last so it wins over a clearing compare write
      if (s_r.count == s_r.compare) begin
         s_nxt.timer_ip = 1'b1; // RULE21
      end
      if (nmi_pulse) begin
         s_nxt.nmi_take = 1'b1; // RULE17
         s_nxt.vector   = `MIC_VEC_RESET; // RULE17
      end else if (s_r.status[`MIC_ST_IE] && !busy && |(ip & im) && !s_r.irq_take) begin
         s_nxt.irq_take = 1'b1; // RULE15 RULE22
         s_nxt.vector   = exc_base_out;
      end
      unique case (cp0_req_in.addr)
         `MIC_IDX_STATUS:  s_nxt.rd_data = s_r.status;
         `MIC_IDX_CAUSE:   s_nxt.rd_data = {16'h0, ip, 8'h0};
         `MIC_IDX_CONFIG:  s_nxt.rd_data = {4'h0, s_r.ep, 8'h0, s_r.be, 15'h0};
         `MIC_IDX_COUNT:   s_nxt.rd_data = s_r.count;
         `MIC_IDX_COMPARE: s_nxt.rd_data = s_r.compare;
         default:          s_nxt.rd_data = 32'h0;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_r        <= '0;
         s_r.status <= `MIC_ST_RESET; // RULE5 RULE6
         s_r.ep     <= `MIC_EP_RESET; // RULE7
         s_r.be     <= `MIC_BE_RESET; // RULE8
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Mode outputs
   always_comb begin
      fp_wide_regs_out      = s_r.status[`MIC_ST_FR]; // RULE6
      write_rate_out        = s_r.ep; // RULE7
      big_endian_out        = s_r.be; // RULE8
      user_swap_active_out  = s_r.status[`MIC_ST_RE] && user_mode; // RULE9
      force_icache_miss_out = s_r.status[`MIC_ST_ITS] && flow_change_in; // RULE10
      exc_base_out          = s_r.status[`MIC_ST_BEV] ? `MIC_VEC_BOOT : `MIC_VEC_NORMAL; // RULE11
      // Refill vector choice per privilege
      xtlb_refill_out       = tlb_miss_in && (user_mode ? s_r.status[`MIC_ST_UX] :
                                              super_mode ? s_r.status[`MIC_ST_SX] :
                                              s_r.status[`MIC_ST_KX]); // RULE12 RULE13 RULE14
      wide_ops_ok_out       = user_mode ? s_r.status[`MIC_ST_UX] :
                              super_mode ? s_r.status[`MIC_ST_SX] : 1'b1; // RULE13 RULE14
      compat_user_xlate_out = !s_r.status[`MIC_ST_UX]; // RULE14
   end

   assign cp0_rd_data_out = s_r.rd_data;
   assign irq_take_out    = s_r.irq_take;
   assign nmi_take_out    = s_r.nmi_take;
   assign take_vector_out = s_r.vector;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_ie_blocks: assert property (ce_in && !s_r.status[`MIC_ST_IE] |=> !irq_take_out) // RULE15
      else $error("interrupt taken while disabled");
   chk_take_cause: assert property (ce_in && !nmi_pulse && s_r.status[`MIC_ST_IE] && !busy && |(ip & im)
                                    && !s_r.irq_take |=> irq_take_out) // RULE22
      else $error("pending unmasked interrupt not taken");
   chk_nmi_vector: assert property (ce_in && nmi_pulse |=> nmi_take_out && take_vector_out == `MIC_VEC_RESET) // RULE17
      else $error("nonmaskable not sent to reset vector");
   chk_timer_set: assert property (ce_in && s_r.count == s_r.compare |=> s_r.timer_ip) // RULE21
      else $error("timer match lost");
   chk_sw_hold: assert property (ce_in && !wr_hit(cp0_req_in, `MIC_IDX_CAUSE) |=> $stable(s_r.sw_ip)) // RULE20
      else $error("software pending changed by hardware");
   chk_base_vec: assert property (irq_take_out |-> take_vector_out == ($past(s_r.status[`MIC_ST_BEV]) ?
                                  `MIC_VEC_BOOT : `MIC_VEC_NORMAL)) // RULE11
      else $error("exception base wrong");
   chk_rp_quarter: assert property (ce_in && wr_hit(cp0_req_in, `MIC_IDX_STATUS) && cp0_req_in.data[`MIC_ST_RP]
                                    && !clk_out.reduced |-> ##[1:16] clk_out.pipe_quarter) // RULE1 RULE3
      else $error("reduced power switch late");
   chk_rp_reset: assert property ($fell(reset_in) |-> !s_r.status[`MIC_ST_RP] && !clk_out.reduced) // RULE5
      else $error("reset left reduced power");
   cov_irq: cover property (irq_take_out);
   cov_nmi: cover property (nmi_take_out);
endmodule
`default_nettype wire

// *** tb/mic_agent.sv ***
// Purpose: External agent model for pins and external writes
// Assumes: Drives on the falling edge of the master clock
// Notes:   Bus is inverted outside data cycles
`timescale 1ns/1ps
`default_nettype none
module mic_agent (
   input  wire logic        clk_in,
   output logic             nmi_n_out,
   output logic [4:0]       irq_n_out,
   output logic             wr_out,
   output logic [31:0]      data_out
);
   initial begin
      nmi_n_out = 1'b1;
      irq_n_out = 5'h1f;
      wr_out    = 1'b0;
      data_out  = 32'h0;
   end
   // ==========
   // Pin levels, changed only here
   task automatic pins(input logic n, input logic [4:0] i);
      nmi_n_out = n;
      irq_n_out = i;
   endtask
   // ==========
   // One data cycle, stale data never looks valid
   task automatic xw(input logic [31:0] d);
      @(negedge clk_in);
      wr_out   = 1'b1;
      data_out = d;
      @(negedge clk_in);
      wr_out   = 1'b0;
      data_out = ~d;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for mode and interrupt control
// Assumes: Inputs change on the falling edge
// Notes:   Reads queue their expectations for the monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_in = 1'b0, reset_in = 1'b1, rd_now = 1'b0, chk = 1'b0, ce = 1'b1;
   mic_pkg::mic_cp0_req_t req = '0;
   mic_pkg::mic_clk_t ck;
   logic [1:0] ratio = 2'h0;
   logic flow = 1'b0, miss = 1'b0, nmi_n, xwr, fpw, be, swp, fim, xtlb, wok, cmp, it, nt;
   logic [4:0] irq_n;
   logic [3:0] wrate;
   logic [31:0] xd, rdd, base, vec, d;
   logic [63:0] q[$];
   logic [3:0] mult [4] = '{4'h6, 4'h4, 4'h3, 4'h2};
   int err_total = 0, checks_done = 0, nirq = 0, nnmi = 0, n, m, t;
   // ==========
   // Clock, partner and design
   initial forever #25 clk_in = ~clk_in;
   mic_agent u_agent (.clk_in(clk_in), .nmi_n_out(nmi_n), .irq_n_out(irq_n), .wr_out(xwr), .data_out(xd));
   mic_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .cp0_req_in(req),
      .cp0_rd_data_out(rdd), .nmi_n_in(nmi_n), .ext_irq_n_in(irq_n), .ext_wr_in(xwr),
      .ext_data_in(xd), .clock_ratio_select_in(ratio), .flow_change_in(flow), .tlb_miss_in(miss),
      .clk_out(ck), .fp_wide_regs_out(fpw), .write_rate_out(wrate), .big_endian_out(be),
      .user_swap_active_out(swp), .force_icache_miss_out(fim), .xtlb_refill_out(xtlb),
      .wide_ops_ok_out(wok), .compat_user_xlate_out(cmp), .exc_base_out(base),
      .irq_take_out(it), .nmi_take_out(nt), .take_vector_out(vec));
   // ==========
   // Tasks
   task automatic check(input string s, input logic [31:0] g, e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic op(input logic w, input logic [4:0] a, input logic [31:0] v);
      @(negedge clk_in);
      req = '{w, a, v};
      rd_now = !w;
   endtask
   task automatic idle(input int k);
      @(negedge clk_in);
      req.wr = 1'b0;
      rd_now = 1'b0;
      repeat (k) @(negedge clk_in);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] mk, e);
      q.push_back({mk, e});
      op(1'b0, a, 32'h0);
      idle(1);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========
   // Monitor: read data stands one cycle after the address
   always @(posedge clk_in) chk <= rd_now;
   always @(negedge clk_in) begin
      if (chk && q.size() > 0) begin
         check("read", rdd & q[0][63:32], q[0][31:0]);
         void'(q.pop_front());
      end
      if (it === 1'b1) nirq++;
      if (nt === 1'b1) nnmi++;
   end
   initial begin
      #(20000 * 50);
      err_total++;
      end_of_test();
   end
   // ==========
   // Tests
   initial begin
      void'($urandom(32'h1c3b4ad6));
      repeat (4) @(negedge clk_in);
      reset_in = 1'b0;
      check("rate", wrate, 4'h0);
      check("order", be, 1'b1);
      check("fpw", fpw, 1'b0);
      rd(12, '1, 32'h0040_0004);
      for (int i = 0; i < 3; i++) begin
         ratio = 2'($urandom);
         d = $urandom & 32'h0740_00e0;
         d[4:3] = i[1:0];
         op(1'b1, 12, d);
         idle(5);
         rd(12, '1, d);
         flow = 1'b1;
         miss = 1'b1;
         #5;
         check("mult", ck.pipe_half_mult, mult[ratio]);
         check("sys", ck.sys_en, 1'b1);
         check("fpw", fpw, d[26]);
         check("swap", swp, d[25] && i == 2);
         check("miss", fim, d[24]);
         check("base", base, d[22] ? 32'hbfc0_0000 : 32'h8000_0000);
         check("xtlb", xtlb, d[7 - i]);
         check("wide", wok, i == 0 ? 1'b1 : d[7 - i]);
         check("compat", cmp, !d[5]);
         flow = 1'b0;
         miss = 1'b0;
         $display("test modes %0d done", i);
      end
      op(1'b1, 12, 32'h0800_0000);
      idle(0);
      for (n = 0; n < 20 && ck.reduced !== 1'b1; n++) @(negedge clk_in);
      check("switch", 32'(n < 16), 1);
      m = 0;
      t = 0;
      repeat (16) begin
         m += ck.sys_en;
         t += ck.tert_en;
         @(negedge clk_in);
      end
      check("sys", 32'(m), 4);
      check("tert", 32'(t), 4);
      check("quarter", ck.pipe_quarter, 1'b1);
      reset_in = 1'b1;
      idle(2);
      reset_in = 1'b0;
      check("reduced", ck.reduced, 1'b0);
      op(1'b1, 16, 32'h0a00_0000);
      idle(1);
      check("rate", wrate, 4'ha);
      check("order", be, 1'b0);
      ce = 1'b0;
      op(1'b1, 16, 32'h0);
      idle(1);
      ce = 1'b1;
      check("frozen", wrate, 4'ha);
      op(1'b1, 11, 32'h100);
      op(1'b1, 9, 32'h0);
      idle(1);
      rd(13, 32'h8000, 32'h0);
      idle(300);
      rd(13, 32'h8000, 32'h8000);
      op(1'b1, 13, '1);
      idle(1);
      rd(13, 32'h0300, 32'h0300);
      op(1'b1, 13, 32'h0);
      idle(1);
      rd(13, 32'h0300, 32'h0);
      $display("test timer done");
      op(1'b1, 12, 32'h0000_0400);
      idle(0);
      u_agent.xw(32'h0001_0001);
      idle(1);
      rd(13, 32'h7c00, 32'h0400);
      nirq = 0;
      idle(10);
      check("noirq", 32'(nirq), 0);
      op(1'b1, 12, 32'h0000_0401);
      idle(10);
      check("irq", 32'(nirq != 0), 1);
      check("vec", vec, 32'h8000_0000);
      u_agent.xw(32'h0001_0000);
      u_agent.pins(1'b1, 5'h17);
      idle(6);
      nirq = 0;
      rd(13, 32'h7c00, 32'h2000);
      idle(6);
      check("masked", 32'(nirq), 0);
      u_agent.pins(1'b1, 5'h1f);
      op(1'b1, 12, 32'h0);
      idle(6);
      rd(13, 32'h7c00, 32'h0);
      $display("test irq done");
      nnmi = 0;
      u_agent.pins(1'b0, 5'h1f);
      idle(8);
      u_agent.pins(1'b1, 5'h1f);
      check("nmi", 32'(nnmi != 0), 1);
      check("nvec", vec, 32'hbfc0_0000);
      idle(6);
      nnmi = 0;
      u_agent.xw(32'h0040_0040);
      idle(4);
      check("xnmi", 32'(nnmi != 0), 1);
      u_agent.xw(32'h0040_0000);
      $display("test nmi done");
      end_of_test();
   end
endmodule
`default_nettype wire
